// ===== hdl/pdm_pkg.sv
// constants, types and lookup functions for the pin driver mode control
`default_nettype none
package pdm_pkg;
   // =================================================================
   // sizes and register map
   localparam int NUM_CH = 4;
   localparam int CH_SEL_LSB = 3;
   localparam int CH_SEL_MSB = 4;
   localparam int REG_SEL_BIT = 2;
   localparam logic [2:0] CHAN_SPACE_TOP = 3'h0;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam int CTRL_W = 5;
   localparam int CAL_W = 10;

   // =================================================================
   // output states, one-hot
   typedef enum logic [5:0] {
      PDM_OUT_LOW = 6'h01,
      PDM_OUT_HIGH = 6'h02,
      PDM_OUT_TERM = 6'h04,
      PDM_OUT_HIZ = 6'h08,
      PDM_OUT_HV = 6'h10,
      PDM_OUT_LEAK = 6'h20
   } pdm_out_e;

   // =================================================================
   // carriers
   typedef struct packed {
      logic slew_select_msb;
      logic slew_select_lsb;
      logic termination_select;
      logic high_voltage_serial_enable;
      logic low_leakage_select;
   } pdm_ctrl_s;

   typedef struct packed {
      logic [3:0] output_resistance_trim;
      logic [2:0] droop_long_amount;
      logic [2:0] droop_short_amount;
   } pdm_cal_s;

   typedef struct packed {
      logic high_voltage_pin_enable_n;
      logic [NUM_CH-1:0] receive_input;
      logic [NUM_CH-1:0] receive_input_complement;
      logic [NUM_CH-1:0] drive_data;
      logic [NUM_CH-1:0] drive_data_complement;
   } pdm_pins_s;

   // =================================================================
   // reset values
   localparam pdm_ctrl_s CTRL_RST = 5'h00;
   localparam logic [1:0] SLEW_RST = 2'h0;
   localparam logic [2:0] DROOP_RST = 3'h0;
   localparam logic [3:0] TRIM_RST = 4'h8;
   localparam pdm_cal_s CAL_RST = {TRIM_RST, DROOP_RST, DROOP_RST};
   // high-voltage pin idles inactive so reset never looks like a request
   localparam pdm_pins_s PINS_RST = {1'b1, 16'h0000};

   // =================================================================
   // setting decodes
   localparam logic [6:0] SLEW_PCT_100 = 7'h64;
   localparam logic [6:0] SLEW_PCT_75 = 7'h4b;
   localparam logic [6:0] SLEW_PCT_50 = 7'h32;
   localparam logic [6:0] SLEW_PCT_25 = 7'h19;
   localparam logic [7:0] DROOP_TENTHS_MAX = 8'h96;
   localparam logic signed [12:0] TRIM_MIN_MOHM = -13'sh0b40;
   localparam logic signed [12:0] TRIM_STEP_MOHM = 13'sh0168;

   function automatic logic [6:0] slew_pct(input logic [1:0] code);
      case (code)
         2'h0: slew_pct = SLEW_PCT_100;
         2'h1: slew_pct = SLEW_PCT_75;
         2'h2: slew_pct = SLEW_PCT_50;
         default: slew_pct = SLEW_PCT_25;
      endcase
   endfunction

   // equal steps of 15.0 / 7 percent, in tenths
   function automatic logic [7:0] droop_tenths(input logic [2:0] code);
      case (code)
         3'h0: droop_tenths = 8'h00;
         3'h1: droop_tenths = 8'h15;
         3'h2: droop_tenths = 8'h2b;
         3'h3: droop_tenths = 8'h40;
         3'h4: droop_tenths = 8'h56;
         3'h5: droop_tenths = 8'h6b;
         3'h6: droop_tenths = 8'h81;
         default: droop_tenths = DROOP_TENTHS_MAX;
      endcase
   endfunction

   function automatic logic signed [12:0] trim_mohm(input logic [3:0] code);
      logic signed [12:0] steps;
      steps = $signed({9'h000, code});
      trim_mohm = 13'(TRIM_MIN_MOHM + steps * TRIM_STEP_MOHM);
   endfunction

   function automatic logic [31:0] be_merge(input logic [31:0] old,
      input logic [31:0] wdata, input logic [3:0] be);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[b*8 +: 8] = wdata[b*8 +: 8];
         end
      end
      be_merge = res;
   endfunction
endpackage
`default_nettype wire

// ===== hdl/pdm_chan_decode.sv
// output state decode of one driver channel
`default_nettype none
module pdm_chan_decode
   import pdm_pkg::*;
(
   input wire logic low_leakage_select,
   input wire logic high_voltage_serial_enable,
   input wire logic termination_select,
   input wire logic high_voltage_pin_enable_n,
   input wire logic receive_input,
   input wire logic drive_data,
   output pdm_out_e out_state
);
   // =================================================================
   // priority: leak, pin request, drive, serial request, receive
   always_comb begin
      if (low_leakage_select) begin
         out_state = PDM_OUT_LEAK; // R01
      end else if (!high_voltage_pin_enable_n) begin
         out_state = PDM_OUT_HV; // R05
      end else if (!receive_input) begin
         out_state = drive_data ? PDM_OUT_HIGH : PDM_OUT_LOW; // R03
      end else if (high_voltage_serial_enable) begin
         out_state = PDM_OUT_HV; // R05
      end else begin
         // data ignored while receiving
         out_state = termination_select ? PDM_OUT_TERM : PDM_OUT_HIZ; // R04
      end
   end
endmodule
`default_nettype wire

// ===== hdl/pdm_top.sv
// register file, pin sampling and output decode of the quad pin driver
`default_nettype none
// =================================================================
// Behaviour
// (R01) A set low-leak bit puts its channel in low leak over everything else.
// (R02) Each channel has its own low-leak bit that leaves the others alone.
// (R03) Leak off, pin high, receive low: drive high on data 1, low on data 0.
// (R04) Leak off, pin high, serial bit 0, receive high: termination or hi-z.
// (R05) Leak off: high-voltage on pin low, or on serial bit and receive high.
// (R06) High/low drive timing does not depend on the serial high-voltage bit.
// (R07) The controller should enter high voltage only from a drive state.
// (R08) Slew code 00/01/10/11 selects 100/75/50/25 percent of full slew.
// (R09) Slew bits are zero after power-up and while reset is held.
// (R10) A 3-bit short droop field sets 0.0 to 15.0 percent in equal steps.
// (R11) A separate 3-bit long droop field uses the same mapping.
// (R12) Both droop fields reset to zero, no compensation.
// (R13) The 4-bit resistance trim resets to code 1000, nominal.
// (R14) Trim code 0 is nominal minus 2.88 ohm, plus 0.36 ohm per step.
// (R15) Settings are per channel and the decode follows every input change; a pair with equal true and complement holds its last good value.
module pdm_top
   import pdm_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic HIGH_VOLTAGE_PIN_ENABLE_N,
   input wire logic [NUM_CH-1:0] RECEIVE_INPUT,
   input wire logic [NUM_CH-1:0] RECEIVE_INPUT_COMPLEMENT,
   input wire logic [NUM_CH-1:0] DRIVE_DATA,
   input wire logic [NUM_CH-1:0] DRIVE_DATA_COMPLEMENT,
   output pdm_out_e [NUM_CH-1:0] CHANNEL_PIN_OUTPUT,
   output logic [NUM_CH-1:0][6:0] SLEW_RATE_PCT,
   output logic [NUM_CH-1:0][7:0] DROOP_SHORT_TENTHS,
   output logic [NUM_CH-1:0][7:0] DROOP_LONG_TENTHS,
   output logic signed [NUM_CH-1:0][12:0] RESISTANCE_OFFSET_MOHM
);
   // =================================================================
   // pin synchroniser
   pdm_pins_s pins_raw;
   pdm_pins_s pin_meta_ff;
   pdm_pins_s pin_sync_ff;

   assign pins_raw = {HIGH_VOLTAGE_PIN_ENABLE_N, RECEIVE_INPUT,
      RECEIVE_INPUT_COMPLEMENT, DRIVE_DATA, DRIVE_DATA_COMPLEMENT};

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         pin_meta_ff <= PINS_RST;
         pin_sync_ff <= PINS_RST;
      end else begin
         pin_meta_ff <= pins_raw;
         pin_sync_ff <= pin_meta_ff;
      end
   end

   // =================================================================
   // differential qualify
   // equal true and complement is a crossing glitch: keep last good value
   logic [NUM_CH-1:0] recv_v;
   logic [NUM_CH-1:0] data_v;
   logic [NUM_CH-1:0] recv_hold_ff;
   logic [NUM_CH-1:0] data_hold_ff;

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         recv_v[c] = (pin_sync_ff.receive_input[c] ^
            pin_sync_ff.receive_input_complement[c]) ?
            pin_sync_ff.receive_input[c] : recv_hold_ff[c];
         data_v[c] = (pin_sync_ff.drive_data[c] ^
            pin_sync_ff.drive_data_complement[c]) ?
            pin_sync_ff.drive_data[c] : data_hold_ff[c];
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         recv_hold_ff <= '0;
         data_hold_ff <= '0;
      end else begin
         recv_hold_ff <= recv_v;
         data_hold_ff <= data_v;
      end
   end

   // =================================================================
   // bus slave: one wait cycle, answer at the second edge
   pdm_ctrl_s [NUM_CH-1:0] ctrl_ff;
   pdm_ctrl_s [NUM_CH-1:0] nxt_ctrl;
   pdm_cal_s [NUM_CH-1:0] cal_ff;
   pdm_cal_s [NUM_CH-1:0] nxt_cal;
   pdm_out_e [NUM_CH-1:0] out_state_ff;
   logic ack_ff;
   logic nxt_ack;
   logic [31:0] rdata_ff;
   logic [31:0] nxt_rdata;
   logic [31:0] wr_merged;
   logic bus_req;
   logic sel_chan;
   logic sel_cal;
   logic [1:0] sel_ch;
   logic wr_go;

   assign bus_req = AVS_READ | AVS_WRITE;
   assign AVS_WAITREQUEST = bus_req & ~ack_ff;
   assign sel_ch = AVS_ADDRESS[CH_SEL_MSB:CH_SEL_LSB];
   assign sel_cal = AVS_ADDRESS[REG_SEL_BIT];
   assign sel_chan = (AVS_ADDRESS[7:5] == CHAN_SPACE_TOP) &&
      (AVS_ADDRESS[1:0] == 2'h0);
   assign wr_go = AVS_WRITE & ack_ff & sel_chan;
   assign AVS_READDATA = rdata_ff;

   always_comb begin
      nxt_ack = bus_req & ~ack_ff;
      nxt_rdata = rdata_ff;
      nxt_ctrl = ctrl_ff;
      nxt_cal = cal_ff;
      wr_merged = be_merge(sel_cal ? 32'(cal_ff[sel_ch]) :
         32'(ctrl_ff[sel_ch]), AVS_WRITEDATA, AVS_BYTEENABLE);
      if (AVS_READ && !ack_ff) begin
         // unmapped words read as zero
         nxt_rdata = 32'h0000_0000;
         if (sel_chan && sel_cal) begin
            nxt_rdata = 32'(cal_ff[sel_ch]);
         end else if (sel_chan) begin
            nxt_rdata = 32'(ctrl_ff[sel_ch]);
         end else if (AVS_ADDRESS == ADDR_STATUS) begin
            nxt_rdata = 32'(out_state_ff);
         end
      end
      // only the addressed channel changes
      if (wr_go && sel_cal) begin
         nxt_cal[sel_ch] = pdm_cal_s'(wr_merged[CAL_W-1:0]); // R02 R15
      end else if (wr_go) begin
         nxt_ctrl[sel_ch] = pdm_ctrl_s'(wr_merged[CTRL_W-1:0]); // R02 R15
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         ctrl_ff <= {NUM_CH{CTRL_RST}}; // R09
         cal_ff <= {NUM_CH{CAL_RST}}; // R12 R13
      end else begin
         ack_ff <= nxt_ack;
         rdata_ff <= nxt_rdata;
         ctrl_ff <= nxt_ctrl;
         cal_ff <= nxt_cal;
      end
   end

   // =================================================================
   // per-channel decode
   pdm_out_e dec_st [NUM_CH];

   for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      pdm_chan_decode u_dec (
         .low_leakage_select(ctrl_ff[i].low_leakage_select),
         .high_voltage_serial_enable(ctrl_ff[i].high_voltage_serial_enable),
         .termination_select(ctrl_ff[i].termination_select),
         .high_voltage_pin_enable_n(pin_sync_ff.high_voltage_pin_enable_n),
         .receive_input(recv_v[i]),
         .drive_data(data_v[i]),
         .out_state(dec_st[i])
      );
   end

   // =================================================================
   // output registers
   pdm_out_e [NUM_CH-1:0] nxt_out;
   logic [NUM_CH-1:0][6:0] slew_ff;
   logic [NUM_CH-1:0][6:0] nxt_slew;
   logic [NUM_CH-1:0][7:0] drp_s_ff;
   logic [NUM_CH-1:0][7:0] nxt_drp_s;
   logic [NUM_CH-1:0][7:0] drp_l_ff;
   logic [NUM_CH-1:0][7:0] nxt_drp_l;
   logic signed [NUM_CH-1:0][12:0] res_ff;
   logic signed [NUM_CH-1:0][12:0] nxt_res;

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         nxt_out[c] = dec_st[c]; // R15
         // slew sees only its own field, never the serial hv bit
         nxt_slew[c] = slew_pct({ctrl_ff[c].slew_select_msb,
            ctrl_ff[c].slew_select_lsb}); // R06 R08
         nxt_drp_s[c] = droop_tenths(cal_ff[c].droop_short_amount); // R10
         nxt_drp_l[c] = droop_tenths(cal_ff[c].droop_long_amount); // R11
         nxt_res[c] = trim_mohm(cal_ff[c].output_resistance_trim); // R14
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         out_state_ff <= '{default: PDM_OUT_HIZ};
         slew_ff <= {NUM_CH{SLEW_PCT_100}};
         drp_s_ff <= '0;
         drp_l_ff <= '0;
         res_ff <= '0;
      end else begin
         out_state_ff <= nxt_out;
         slew_ff <= nxt_slew;
         drp_s_ff <= nxt_drp_s;
         drp_l_ff <= nxt_drp_l;
         res_ff <= nxt_res;
      end
   end

   assign CHANNEL_PIN_OUTPUT = out_state_ff;
   assign SLEW_RATE_PCT = slew_ff;
   assign DROOP_SHORT_TENTHS = drp_s_ff;
   assign DROOP_LONG_TENTHS = drp_l_ff;
   assign RESISTANCE_OFFSET_MOHM = res_ff;

   // =================================================================
   // assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_bus_answer;
      bus_req && !ack_ff |=> !AVS_WAITREQUEST;
   endproperty
   a_bus_answer: assert property (p_bus_answer)
      else $error("bus answer not one cycle after request");

   for (genvar i = 0; i < NUM_CH; i++) begin : g_chk
      property p_leak_wins;
         ctrl_ff[i].low_leakage_select ##1 ctrl_ff[i].low_leakage_select
            |-> CHANNEL_PIN_OUTPUT[i] == PDM_OUT_LEAK;
      endproperty
      a_leak_wins: assert property (p_leak_wins) // R01
         else $error("low leak not taken");

      property p_leak_isolated;
         wr_go && sel_ch != 2'(i)
            |=> $stable(ctrl_ff[i]) && $stable(cal_ff[i]);
      endproperty
      a_leak_isolated: assert property (p_leak_isolated) // R02
         else $error("write to another channel changed this one");

      property p_drive_data;
         !ctrl_ff[i].low_leakage_select &&
            pin_sync_ff.high_voltage_pin_enable_n && !recv_v[i]
            |=> CHANNEL_PIN_OUTPUT[i] ==
            ($past(data_v[i]) ? PDM_OUT_HIGH : PDM_OUT_LOW);
      endproperty
      a_drive_data: assert property (p_drive_data) // R03
         else $error("drive level does not follow data");

      property p_receive;
         !ctrl_ff[i].low_leakage_select && recv_v[i] &&
            pin_sync_ff.high_voltage_pin_enable_n &&
            !ctrl_ff[i].high_voltage_serial_enable
            |=> CHANNEL_PIN_OUTPUT[i] ==
            ($past(ctrl_ff[i].termination_select) ?
            PDM_OUT_TERM : PDM_OUT_HIZ);
      endproperty
      a_receive: assert property (p_receive) // R04
         else $error("receive state wrong");

      property p_high_voltage;
         !ctrl_ff[i].low_leakage_select &&
            (!pin_sync_ff.high_voltage_pin_enable_n ||
            (ctrl_ff[i].high_voltage_serial_enable && recv_v[i]))
            |=> CHANNEL_PIN_OUTPUT[i] == PDM_OUT_HV;
      endproperty
      a_high_voltage: assert property (p_high_voltage) // R05
         else $error("high voltage not entered");

      property p_slew_indep;
         $changed(ctrl_ff[i].high_voltage_serial_enable) &&
            $stable({ctrl_ff[i].slew_select_msb,
            ctrl_ff[i].slew_select_lsb})
            |=> $stable(SLEW_RATE_PCT[i]);
      endproperty
      a_slew_indep: assert property (p_slew_indep) // R06
         else $error("slew moved with serial hv bit");

      property p_slew_quarter;
         ctrl_ff[i].slew_select_msb && ctrl_ff[i].slew_select_lsb
            |=> SLEW_RATE_PCT[i] == SLEW_PCT_25;
      endproperty
      a_slew_quarter: assert property (p_slew_quarter) // R08
         else $error("slew code 3 not 25 percent");

      property p_slew_reset;
         $rose(RST_N) |-> !ctrl_ff[i].slew_select_msb &&
            !ctrl_ff[i].slew_select_lsb;
      endproperty
      a_slew_reset: assert property (p_slew_reset) // R09
         else $error("slew not cleared by reset");

      property p_droop_short_max;
         cal_ff[i].droop_short_amount == 3'h7
            |=> DROOP_SHORT_TENTHS[i] == DROOP_TENTHS_MAX;
      endproperty
      a_droop_short_max: assert property (p_droop_short_max) // R10
         else $error("short droop code 7 not 15.0 percent");

      property p_droop_long_mid;
         cal_ff[i].droop_long_amount == 3'h4
            |=> DROOP_LONG_TENTHS[i] == 8'h56;
      endproperty
      a_droop_long_mid: assert property (p_droop_long_mid) // R11
         else $error("long droop code 4 not 8.6 percent");

      property p_droop_reset;
         $rose(RST_N) |-> cal_ff[i].droop_short_amount == DROOP_RST &&
            cal_ff[i].droop_long_amount == DROOP_RST;
      endproperty
      a_droop_reset: assert property (p_droop_reset) // R12
         else $error("droop not zero after reset");

      property p_trim_reset;
         $rose(RST_N) |-> cal_ff[i].output_resistance_trim == TRIM_RST
            ##1 RESISTANCE_OFFSET_MOHM[i] == 13'sh0000;
      endproperty
      a_trim_reset: assert property (p_trim_reset) // R13
         else $error("trim not nominal after reset");

      property p_trim_min;
         cal_ff[i].output_resistance_trim == 4'h0
            |=> RESISTANCE_OFFSET_MOHM[i] == TRIM_MIN_MOHM;
      endproperty
      a_trim_min: assert property (p_trim_min) // R14
         else $error("trim code 0 not minus 2.88 ohm");

      property p_ctrl_write;
         wr_go && !sel_cal && sel_ch == 2'(i) && AVS_BYTEENABLE[0]
            |=> ctrl_ff[i] == $past(AVS_WRITEDATA[CTRL_W-1:0]);
      endproperty
      a_ctrl_write: assert property (p_ctrl_write) // R15
         else $error("control write not stored");
   end

   c_leak: cover property (CHANNEL_PIN_OUTPUT[0] == PDM_OUT_LEAK);
   c_hv: cover property (CHANNEL_PIN_OUTPUT[1] == PDM_OUT_HV);
   c_term: cover property (CHANNEL_PIN_OUTPUT[2] == PDM_OUT_TERM);
   c_hiz_to_high: cover property (CHANNEL_PIN_OUTPUT[3] == PDM_OUT_HIZ
      ##1 CHANNEL_PIN_OUTPUT[3] == PDM_OUT_HIGH);
endmodule
`default_nettype wire

// ===== tb/pdm_tg_model.sv
// timing generator model that drives the fast pin pairs of the driver
`default_nettype none
module pdm_tg_model
   import pdm_pkg::*;
(
   input wire logic clk,
   output var pdm_pins_s pins
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      pins = PINS_RST;
   end

   // =================================================================
   // pin changes
   // apply makes complements follow the true lines; only glitch leaves a pair invalid
   task automatic apply(input logic hv_n, input logic [NUM_CH-1:0] rcv,
      input logic [NUM_CH-1:0] dat);
      @(posedge clk);
      // pass through a drive state before raising the pin request
      if (!hv_n && pins.high_voltage_pin_enable_n) begin
         pins.receive_input <= '0;
         pins.receive_input_complement <= '1;
         repeat (4) @(posedge clk);
      end
      pins <= '{hv_n, rcv, ~rcv, dat, ~dat};
   endtask

   // receive true flips onto its complement: pair invalid, old value must hold
   task automatic glitch();
      @(posedge clk);
      pins.receive_input <= ~pins.receive_input;
   endtask
endmodule
`default_nettype wire

// ===== tb/pdm_top_tb_top.sv
// self-checking testbench of the quad pin driver mode control
`default_nettype none
module pdm_top_tb_top
   import pdm_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   typedef struct packed {
      logic [2:0] kind;
      logic [1:0] ch;
      logic [31:0] exp;
   } pdm_note_s;
   localparam logic [7:0] DROOP_TAB [8] = '{8'h00, 8'h15, 8'h2b, 8'h40,
      8'h56, 8'h6b, 8'h81, 8'h96};

   logic clk;
   logic rst_n;
   logic [7:0] addr;
   logic rd;
   logic wr;
   logic [31:0] wdata;
   logic [3:0] be;
   logic [31:0] rdata;
   logic waitreq;
   pdm_pins_s pins;
   pdm_out_e [NUM_CH-1:0] state;
   logic [NUM_CH-1:0][6:0] slew;
   logic [NUM_CH-1:0][7:0] dshort;
   logic [NUM_CH-1:0][7:0] dlong;
   logic signed [NUM_CH-1:0][12:0] res;
   int fail_count;
   int checked;
   pdm_note_s notes[$];
   event seen;
   logic [31:0] rd_val;
   logic [NUM_CH-1:0][4:0] ctrl_m;
   logic [NUM_CH-1:0][9:0] cal_m;

   pdm_top dut_u (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(addr),
      .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
      .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .HIGH_VOLTAGE_PIN_ENABLE_N(pins.high_voltage_pin_enable_n),
      .RECEIVE_INPUT(pins.receive_input),
      .RECEIVE_INPUT_COMPLEMENT(pins.receive_input_complement),
      .DRIVE_DATA(pins.drive_data),
      .DRIVE_DATA_COMPLEMENT(pins.drive_data_complement),
      .CHANNEL_PIN_OUTPUT(state), .SLEW_RATE_PCT(slew),
      .DROOP_SHORT_TENTHS(dshort), .DROOP_LONG_TENTHS(dlong),
      .RESISTANCE_OFFSET_MOHM(res));

   pdm_tg_model tg_u (.clk(clk), .pins(pins));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // =================================================================
   // verdict and comparisons
   task automatic close_out();
      if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic cmp_word(input string what, input logic [31:0] e,
      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic cmp_state(input int c, input logic [5:0] e,
      input logic [5:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value state ch%0d expected %h seen %h", c, e, g);
      end
   endtask

   task automatic expect_out(input logic [2:0] k, input int c,
      input logic [31:0] e);
      notes.push_back('{k, 2'(c), e});
      -> seen;
   endtask

   // several notes may land in one time step, so drain them all
   initial begin
      pdm_note_s n;
      forever begin
         @seen;
         while (notes.size() > 0) begin
            n = notes.pop_front();
            case (n.kind)
               3'h0: cmp_word("read data", n.exp, rd_val);
               3'h1: cmp_state(n.ch, n.exp[5:0], state[n.ch]);
               3'h2: cmp_word("slew", n.exp, {25'h0, slew[n.ch]});
               3'h3: cmp_word("short droop", n.exp, {24'h0, dshort[n.ch]});
               3'h4: cmp_word("long droop", n.exp, {24'h0, dlong[n.ch]});
               default: cmp_word("resistance", n.exp, {19'h0, res[n.ch]});
            endcase
         end
      end
   end

   // =================================================================
   // avalon master: request held until waitrequest is sampled low
   task automatic bus_go(input logic is_wr, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] b);
      int n;
      @(posedge clk);
      addr <= a;
      wdata <= d;
      be <= b;
      rd <= ~is_wr;
      wr <= is_wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 50);
      if (n >= 50) begin
         fail_count++;
         close_out();
      end
      rd_val = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, input logic [31:0] e);
      bus_go(1'b0, a, 32'h0, 4'h0);
      expect_out(3'h0, 0, e);
   endtask

   task automatic set_ctrl(input int c, input logic [4:0] v);
      ctrl_m[c] = v;
      bus_go(1'b1, 8'(8 * c), {27'h0, v}, 4'hf);
   endtask

   task automatic set_cal(input int c, input logic [9:0] v);
      cal_m[c] = v;
      bus_go(1'b1, 8'(8 * c + 4), {22'h0, v}, 4'hf);
   endtask

   task automatic check_settings();
      logic [6:0] sp;
      repeat (2) @(posedge clk);
      for (int c = 0; c < NUM_CH; c++) begin
         case (ctrl_m[c][4:3])
            2'h0: sp = 7'h64;
            2'h1: sp = 7'h4b;
            2'h2: sp = 7'h32;
            default: sp = 7'h19;
         endcase
         expect_out(3'h2, c, {25'h0, sp});
         expect_out(3'h3, c, {24'h0, DROOP_TAB[cal_m[c][2:0]]});
         expect_out(3'h4, c, {24'h0, DROOP_TAB[cal_m[c][5:3]]});
         expect_out(3'h5, c, {19'h0,
            13'(-2880 + 360 * int'(cal_m[c][9:6]))});
      end
   endtask

   function automatic pdm_out_e exp_state(input logic [4:0] cw,
      input logic hv_n, input logic r, input logic d);
      if (cw[0]) return PDM_OUT_LEAK;
      if (!hv_n) return PDM_OUT_HV;
      if (!r) return d ? PDM_OUT_HIGH : PDM_OUT_LOW;
      if (cw[1]) return PDM_OUT_HV;
      return cw[2] ? PDM_OUT_TERM : PDM_OUT_HIZ;
   endfunction

   task automatic latency(input logic hvs, output int n);
      set_ctrl(0, {3'h0, hvs, 1'b0});
      tg_u.apply(1'b1, 4'h0, 4'h0);
      repeat (6) @(posedge clk);
      tg_u.apply(1'b1, 4'h0, 4'h1);
      n = 0;
      while (state[0] !== PDM_OUT_HIGH && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         close_out();
      end
   endtask

   // =================================================================
   // main sequence
   initial begin
      int c;
      int lat0;
      int lat1;
      logic hv_n;
      logic [3:0] rv;
      logic [3:0] dv;
      logic [23:0] st;
      rst_n = 1'b0;
      rd = 1'b0;
      wr = 1'b0;
      addr = 8'h00;
      wdata = 32'h0;
      be = 4'h0;
      fail_count = 0;
      checked = 0;
      ctrl_m = '0;
      cal_m = {NUM_CH{10'h200}};
      void'($urandom(32'hf51f42e2));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < NUM_CH; i++) begin
         bus_read(8'(8 * i), 32'h0);
         bus_read(8'(8 * i + 4), 32'h200);
      end
      check_settings();
      bus_go(1'b1, 8'h3c, 32'hffffffff, 4'hf);
      bus_read(8'h3c, 32'h0);
      for (int i = 0; i < 16; i++) begin
         c = $urandom % NUM_CH;
         set_ctrl(c, {i[1:0], 3'h0});
         set_cal(c, {i[3:0], i[2:0], 3'(7 - i)});
         bus_go(1'b1, 8'(8 * c + 4), 32'h3ff, 4'h0);
         bus_read(8'(8 * c + 4), {22'h0, cal_m[c]});
         check_settings();
      end
      for (int t = 0; t < 40; t++) begin
         hv_n = ($urandom % 4) != 0;
         rv = 4'($urandom);
         dv = 4'($urandom);
         // park every channel in a drive state before any hv entry
         tg_u.apply(1'b1, 4'h0, dv);
         for (int i = 0; i < NUM_CH; i++) set_ctrl(i, {2'h0, 3'($urandom)});
         tg_u.apply(hv_n, rv, dv);
         repeat (5) @(posedge clk);
         for (int i = 0; i < NUM_CH; i++) begin
            st[6 * i +: 6] = exp_state(ctrl_m[i], hv_n, rv[i], dv[i]);
            expect_out(3'h1, i, {26'h0, st[6 * i +: 6]});
         end
         bus_read(ADDR_STATUS, {8'h0, st});
      end
      tg_u.glitch();
      repeat (5) @(posedge clk);
      for (int i = 0; i < NUM_CH; i++) begin
         expect_out(3'h1, i, {26'h0, st[6 * i +: 6]});
      end
      latency(1'b0, lat0);
      latency(1'b1, lat1);
      cmp_word("high low timing", lat0, lat1);
      set_ctrl(1, 5'h1f);
      set_cal(1, 10'h0ff);
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      ctrl_m = '0;
      cal_m = {NUM_CH{10'h200}};
      bus_read(8'h08, 32'h0);
      check_settings();
      repeat (3) @(posedge clk);
      close_out();
   end
endmodule
`default_nettype wire
